//--- hw/analog_output_channel_control.sv
// Control logic of a four-channel analog output module: APB registers,
// function code decode, range checking, scaling, diagnostics, fault LED.
// Assumes: APB master on clk_in; fault pins are asynchronous; the
// non-volatile store answers on clk_in with its saved parameter image.
`timescale 1ns/100ps
`include "ao_ctrl_defs.svh"

module analog_output_channel_control #(
  parameter int UPDATE_CYCLES = `UPDATE_CYCLE_US * `CLK_FREQ_MHZ
) (
  input  wire logic                     clk_in,            // 20 MHz clock
  input  wire logic                     sys_rst_in,        // Sync reset, high
  input  wire logic                     psel_in,           // APB select
  input  wire logic                     penable_in,        // APB enable
  input  wire logic                     pwrite_in,         // APB direction
  input  wire logic [7:0]               paddr_in,          // APB byte address
  input  wire logic [31:0]              pwdata_in,         // APB write data
  input  wire logic [3:0]               pstrb_in,          // APB byte strobes
  output logic                          pready_out,        // APB ready
  output logic [31:0]                   prdata_out,        // APB read data
  output logic                          pslverr_out,       // APB error
  input  wire logic                     nv_valid_in,       // Saved image ready
  input  wire logic [47:0]              nv_params_in,      // Saved image
  output logic                          nv_write_out,      // Store pulse
  output logic [47:0]                   nv_data_out,       // Image to store
  input  wire logic [3:0]               short_circuit_in,  // Per channel pin
  input  wire logic [3:0]               open_circuit_in,   // Per channel pin
  input  wire logic                     supply_missing_in, // Supply pin
  input  wire logic                     module_fault_in,   // Internal fault pin
  output ao_ctrl_pkg::code_vec_type     ch_code_out,       // Scaled values
  output logic [3:0]                    ch_active_out,     // Channel on
  output ao_ctrl_pkg::fn_vec_type       ch_func_out,       // Applied codes
  output logic                          diag_send_out,     // Record pulse
  output logic [31:0]                   diag_record_out,   // Record, byte 0 low
  output logic                          fault_indicator_led_out // Fault LED
);
  import ao_ctrl_pkg::*;

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  function automatic func_info_type decode_fn(input logic [7:0] code);
    func_info_type f;
    f = '{valid: 1'b1, active: 1'b1, legacy: 1'b0, current: 1'b0,
          rng: RANGE_BIPOLAR};
    unique case (code)
      `FN_LEG_V_BIP: f.legacy = 1'b1;
      `FN_LEG_V_LZ:  begin f.legacy = 1'b1; f.rng = RANGE_LIVE_ZERO; end
      `FN_LEG_V_UNI: begin f.legacy = 1'b1; f.rng = RANGE_UNIPOLAR; end
      `FN_EXT_V_BIP: f.rng = RANGE_BIPOLAR;
      `FN_EXT_V_LZ:  f.rng = RANGE_LIVE_ZERO;
      `FN_EXT_V_UNI: f.rng = RANGE_UNIPOLAR;
      `FN_LEG_I_BIP: begin f.legacy = 1'b1; f.current = 1'b1; end
      `FN_LEG_I_LZ:  begin
        f.legacy = 1'b1; f.current = 1'b1; f.rng = RANGE_LIVE_ZERO;
      end
      `FN_LEG_I_UNI: begin
        f.legacy = 1'b1; f.current = 1'b1; f.rng = RANGE_UNIPOLAR;
      end
      `FN_EXT_I_BIP: f.current = 1'b1;
      `FN_EXT_I_LZ:  begin f.current = 1'b1; f.rng = RANGE_LIVE_ZERO; end
      `FN_EXT_I_UNI: begin f.current = 1'b1; f.rng = RANGE_UNIPOLAR; end
      `FN_OFF:       f.active = 1'b0;
      `FN_KEEP:      f.active = 1'b1;
      default:       f.valid = 1'b0;
    endcase
    return f;
  endfunction : decode_fn

  // Applies a code to a stored configuration; 00h and bad codes keep it
  function automatic logic [7:0] next_cfg(input logic [7:0] cur,
                                          input logic [7:0] code);
    func_info_type f;
    f = decode_fn(code);
    if (!f.valid || code == `FN_KEEP) begin
      return cur;
    end
    return code;
  endfunction : next_cfg

  // Range check and normalisation to the extended full scale
  function automatic logic [16:0] scale_value(input logic [15:0] word,
                                              input logic [7:0]  cfg);
    func_info_type     f;
    logic signed [16:0] v;
    logic signed [16:0] lo;
    logic signed [16:0] hi;
    logic signed [21:0] prod;
    f    = decode_fn(cfg);
    v    = 17'(signed'(word));
    hi   = f.legacy ? `LEG_MAX : `EXT_MAX;
    lo   = `UNI_MIN;
    prod = 22'(v) * 22'(`LEG_SCALE_MUL);
    if (f.rng == RANGE_BIPOLAR) begin
      lo = f.legacy ? `LEG_BIP_MIN : `EXT_BIP_MIN;
    end else if (f.rng == RANGE_LIVE_ZERO) begin
      lo = f.legacy ? `LEG_LZ_MIN : `EXT_LZ_MIN;
    end
    if (!f.active || v > hi || v < lo) begin
      return 17'h00000;
    end
    if (f.legacy) begin
      return 17'(prod >>> `LEG_SCALE_SHIFT);
    end
    return v;
  endfunction : scale_value

  // --------------------------------------------------------------------
  // Pin synchronisers: change accepted once stages two and three agree
  // --------------------------------------------------------------------
  localparam int NPIN = 10;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s1_reg;
  logic [NPIN-1:0] pin_s2_reg;
  logic [NPIN-1:0] pin_s3_reg;
  logic [NPIN-1:0] pin_reg;

  assign pin_raw = {module_fault_in, supply_missing_in, open_circuit_in,
                    short_circuit_in};

  for (genvar p = 0; p < NPIN; p++) begin : g_sync
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        pin_s1_reg[p] <= 1'b0;
        pin_s2_reg[p] <= 1'b0;
        pin_s3_reg[p] <= 1'b0;
        pin_reg[p]    <= 1'b0;
      end else begin
        pin_s1_reg[p] <= pin_raw[p];
        pin_s2_reg[p] <= pin_s1_reg[p];
        pin_s3_reg[p] <= pin_s2_reg[p];
        if (pin_s2_reg[p] == pin_s3_reg[p]) begin
          pin_reg[p] <= pin_s3_reg[p];
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // APB decode
  // --------------------------------------------------------------------
  logic        setup;
  logic        access;
  logic        wr_en;
  logic [7:0]  rel;
  logic        in_out;
  logic        in_par;
  logic        in_diag;
  logic        in_stat;
  logic        mapped;
  logic [5:0]  par_wr;
  logic [3:0]  out_wr;

  assign setup   = psel_in && !penable_in;
  assign access  = psel_in && penable_in;
  assign in_out  = paddr_in < (`OUT_BASE + 8'((`OUT_IDX_CH3 + 8'h01) * 4));
  assign in_par  = paddr_in >= `PARAM_BASE && paddr_in < `PARAM_BASE + 8'h18;
  assign in_diag = paddr_in >= `DIAG_BASE && paddr_in < `DIAG_BASE + 8'h10;
  assign in_stat = paddr_in == `STATUS_ADDR;
  assign rel     = paddr_in - (in_par ? `PARAM_BASE : in_diag ? `DIAG_BASE
                                                      : `OUT_BASE);
  // Word slots only; odd output indices are unmapped and answer with an error
  assign mapped  = paddr_in[1:0] == 2'b00 &&
                   ((in_out && rel[3:2] == 2'b00 && !rel[4] ? 1'b1 :
                     in_out && (rel[5:2] % 2) == 0) || in_par || in_diag ||
                    in_stat);
  assign wr_en   = access && pwrite_in && mapped;
  assign pready_out  = access;
  assign pslverr_out = access && !mapped;

  for (genvar c = 0; c < 4; c++) begin : g_wdec
    assign out_wr[c] = wr_en && in_out && rel == 8'(8'(2 * c) * 4);
  end
  for (genvar b = 0; b < 6; b++) begin : g_pdec
    assign par_wr[b] = wr_en && in_par && rel == 8'(b * 4) && pstrb_in[0];
  end

  // --------------------------------------------------------------------
  // Output words, staged until the next update cycle
  // --------------------------------------------------------------------
  logic [3:0][15:0] word_reg;

  for (genvar c = 0; c < 4; c++) begin : g_word
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        word_reg[c] <= 16'h0000;
      end else if (out_wr[c]) begin
        if (pstrb_in[1]) begin
          word_reg[c][15:8] <= pwdata_in[15:8];
        end
        if (pstrb_in[0]) begin
          word_reg[c][7:0] <= pwdata_in[7:0];
        end
      end
    end
  end

  // --------------------------------------------------------------------
  // Parameters and restore from non-volatile storage
  // --------------------------------------------------------------------
  logic             irq_en_reg;
  fn_vec_type       fn_reg;
  fn_vec_type       cfg_reg;
  logic [3:0]       bad_reg;
  logic             restore_pending_reg;
  logic             restore;

  assign restore = restore_pending_reg && nv_valid_in;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      restore_pending_reg <= 1'b1;
    end else if (restore || par_wr != 6'b000000) begin
      restore_pending_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      irq_en_reg <= 1'b0;
    end else if (restore) begin
      irq_en_reg <= nv_params_in[`CTRL_IRQ_EN_BIT];
    end else if (par_wr[0]) begin
      irq_en_reg <= pwdata_in[`CTRL_IRQ_EN_BIT];
    end
  end

  for (genvar c = 0; c < 4; c++) begin : g_cfg
    logic          load;
    logic [7:0]    code;
    func_info_type info;
    assign load = restore || par_wr[c + 2];
    assign code = restore ? nv_params_in[8 * (c + 2) +: 8] : pwdata_in[7:0];
    assign info = decode_fn(code);
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        fn_reg[c]  <= `FN_DEFAULT;
        cfg_reg[c] <= `FN_DEFAULT;
        bad_reg[c] <= 1'b0;
      end else if (load) begin
        fn_reg[c]  <= code;
        cfg_reg[c] <= next_cfg(cfg_reg[c], code);
        bad_reg[c] <= !info.valid;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      nv_write_out <= 1'b0;
      nv_data_out  <= 48'h000000000000;
    end else begin
      nv_write_out <= par_wr != 6'b000000;
      nv_data_out  <= {fn_reg, 8'h00, 1'b0, irq_en_reg, 6'h00};
    end
  end

  // --------------------------------------------------------------------
  // Update cycle: all channels refreshed together
  // --------------------------------------------------------------------
  logic [$clog2(UPDATE_CYCLES)-1:0] tick_cnt_reg;
  logic                             tick;

  assign tick = tick_cnt_reg == ($clog2(UPDATE_CYCLES))'(UPDATE_CYCLES - 1);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in || tick) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end

  for (genvar c = 0; c < 4; c++) begin : g_out
    func_info_type info;
    assign info = decode_fn(cfg_reg[c]);
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        ch_code_out[c]   <= 17'h00000;
        ch_active_out[c] <= 1'b0;
        ch_func_out[c]   <= `FN_DEFAULT;
      end else if (tick) begin
        ch_code_out[c]   <= scale_value(word_reg[c], cfg_reg[c]);
        ch_active_out[c] <= info.active;
        ch_func_out[c]   <= cfg_reg[c];
      end
    end
  end

  // --------------------------------------------------------------------
  // Diagnostics and fault LED
  // --------------------------------------------------------------------
  logic [3:0] ch_err;
  logic [7:0] diag0;
  logic [7:0] diag1;
  logic [7:0] diag0_prev_reg;

  for (genvar c = 0; c < 4; c++) begin : g_err
    func_info_type info;
    assign info      = decode_fn(cfg_reg[c]);
    assign ch_err[c] = info.active &&
                       ((pin_reg[c] && !info.current) ||
                        (pin_reg[c + 4] && info.current));
  end

  always_comb begin
    diag0                      = 8'h00;
    diag0[`DIAG_MALFUNC_BIT]   = pin_reg[9];
    diag0[`DIAG_EXT_ERR_BIT]   = pin_reg[8];
    diag0[`DIAG_CHAN_ERR_BIT]  = |ch_err;
    diag0[`DIAG_WRONG_PAR_BIT] = |bad_reg;
    diag1                      = {3'b000, |ch_err, `DIAG_CLASS_ANALOG};
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      diag0_prev_reg  <= 8'h00;
      diag_send_out   <= 1'b0;
      diag_record_out <= 32'h00000000;
    end else begin
      diag0_prev_reg <= diag0;
      diag_send_out  <= irq_en_reg && diag0 != 8'h00 &&
                        diag0 != diag0_prev_reg;
      diag_record_out <= {8'h00, 8'h00, diag1, diag0};
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      fault_indicator_led_out <= 1'b0;
    end else begin
      fault_indicator_led_out <= |ch_err || |bad_reg || pin_reg[8];
    end
  end

  // --------------------------------------------------------------------
  // Read data, loaded in the setup phase
  // --------------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      prdata_out <= 32'h00000000;
    end else if (setup) begin
      prdata_out <= 32'h00000000;
      if (in_par && rel == 8'(`PARAM_IDX_CTRL * 4)) begin
        prdata_out[`CTRL_IRQ_EN_BIT] <= irq_en_reg;
      end else if (in_par && rel >= 8'(`PARAM_IDX_FN0 * 4)) begin
        prdata_out[7:0] <= fn_reg[rel[4:2] - 3'(`PARAM_IDX_FN0)];
      end else if (in_diag && rel == 8'(`DIAG_IDX_ERR * 4)) begin
        prdata_out[7:0] <= diag0;
      end else if (in_diag && rel == 8'(`DIAG_IDX_CLASS * 4)) begin
        prdata_out[7:0] <= diag1;
      end else if (in_stat) begin
        prdata_out[17:0] <= {fault_indicator_led_out, restore_pending_reg,
                             ch_active_out, bad_reg, pin_reg[7:0] == 8'h00,
                             ch_err, pin_reg[9:8], 1'b0};
      end
    end
  end

endmodule : analog_output_channel_control

//--- hw/ao_ctrl_defs.svh
// Constants of the four-channel analog output control block.
// Assumes: included by the design module by bare name.
`ifndef AO_CTRL_DEFS_SVH
`define AO_CTRL_DEFS_SVH

// ----------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------
`define CLK_FREQ_MHZ        20
`define UPDATE_CYCLE_US     1800

// ----------------------------------------------------------------------
// Register indices; byte address is four times the index plus a base
// ----------------------------------------------------------------------
`define OUT_IDX_CH0         8'h00
`define OUT_IDX_CH1         8'h02
`define OUT_IDX_CH2         8'h04
`define OUT_IDX_CH3         8'h06
`define PARAM_IDX_CTRL      8'h00
`define PARAM_IDX_RSVD      8'h01
`define PARAM_IDX_FN0       8'h02
`define DIAG_IDX_ERR        8'h00
`define DIAG_IDX_CLASS      8'h01
`define DIAG_IDX_RSVD2      8'h02
`define DIAG_IDX_RSVD3      8'h03
`define OUT_BASE            8'h00
`define PARAM_BASE          8'h40
`define DIAG_BASE           8'h80
`define STATUS_ADDR         8'hc0

// ----------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------
`define CTRL_IRQ_EN_BIT     6
`define DIAG_MALFUNC_BIT    0
`define DIAG_EXT_ERR_BIT    2
`define DIAG_CHAN_ERR_BIT   3
`define DIAG_WRONG_PAR_BIT  7
`define DIAG_CHAN_INFO_BIT  4
`define DIAG_CLASS_ANALOG   4'h5

// ----------------------------------------------------------------------
// Function codes
// ----------------------------------------------------------------------
`define FN_KEEP             8'h00
`define FN_LEG_V_BIP        8'h01
`define FN_LEG_V_LZ         8'h02
`define FN_LEG_I_BIP        8'h03
`define FN_LEG_I_LZ         8'h04
`define FN_LEG_V_UNI        8'h05
`define FN_LEG_I_UNI        8'h06
`define FN_EXT_V_BIP        8'h09
`define FN_EXT_V_LZ         8'h0a
`define FN_EXT_I_BIP        8'h0b
`define FN_EXT_I_LZ         8'h0c
`define FN_EXT_V_UNI        8'h0d
`define FN_EXT_I_UNI        8'h0e
`define FN_OFF              8'hff
`define FN_DEFAULT          8'h09

// ----------------------------------------------------------------------
// Value limits (signed 17 bit)
// ----------------------------------------------------------------------
`define LEG_MAX             17'sh05000
`define LEG_BIP_MIN         -17'sh05000
`define LEG_LZ_MIN          -17'sh01000
`define EXT_MAX             17'sh07eff
`define EXT_BIP_MIN         -17'sh07f00
`define EXT_LZ_MIN          -17'sh01b00
`define UNI_MIN             17'sh00000
`define LEG_SCALE_MUL       17'sh0001b
`define LEG_SCALE_SHIFT     4

`endif

//--- hw/ao_ctrl_pkg.sv
// Types shared by the analog output control block and its bench.
// Assumes: ao_ctrl_defs.svh holds all numeric constants.
package ao_ctrl_pkg;

  // --------------------------------------------------------------------
  // Range classes and decoded function information
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    RANGE_BIPOLAR,
    RANGE_LIVE_ZERO,
    RANGE_UNIPOLAR
  } range_type;

  typedef struct packed {
    logic      valid;
    logic      active;
    logic      legacy;
    logic      current;
    range_type rng;
  } func_info_type;

  typedef logic [3:0][7:0]  fn_vec_type;
  typedef logic [3:0][16:0] code_vec_type;

endpackage : ao_ctrl_pkg

//--- sim/analog_output_channel_control_asserts.sv
// Port-level checks of the analog output control block.
// Assumes: bound into the block; one clock domain.
`timescale 1ns/100ps
module analog_output_channel_control_asserts
  import ao_ctrl_pkg::*;
(
  input wire logic clk_in, sys_rst_in, psel_in, penable_in, pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [3:0]  pstrb_in,
  input wire logic        pready_out, pslverr_out, nv_write_out, supply_missing_in,
  input wire logic [31:0] prdata_out, diag_record_out,
  input wire ao_ctrl_pkg::code_vec_type ch_code_out,
  input wire ao_ctrl_pkg::fn_vec_type   ch_func_out,
  input wire logic [3:0]  ch_active_out,
  input wire logic        diag_send_out, fault_indicator_led_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  apb_ready_a: assert property (psel_in && penable_in |-> pready_out)
    else $error("pready missing in access phase");
  err_phase_a: assert property (pslverr_out |-> psel_in && penable_in)
    else $error("pslverr outside access phase");
  nv_store_a: assert property (psel_in && penable_in && pwrite_in && paddr_in == 8'h48
    && pstrb_in[0] |=> nv_write_out ##1 !nv_write_out)
    else $error("parameter write not stored");
  diag_rsvd_a: assert property (psel_in && penable_in && !pwrite_in && paddr_in == 8'h88
    |-> prdata_out == 32'h0)
    else $error("unused diagnostic byte not zero");
  diag_frame_a: assert property (diag_send_out |-> diag_record_out[31:16] == 16'h0
    && diag_record_out[11:8] == 4'h5)
    else $error("diagnostic record frame wrong");
  off_zero_a: assert property (ch_code_out[3] != 17'h0 |-> ch_active_out[3])
    else $error("inactive channel drives a value");
  led_supply_a: assert property (supply_missing_in [*8] |-> fault_indicator_led_out)
    else $error("fault LED off with supply missing");
  wrong_par_a: assert property ($rose(diag_record_out[7]) |-> ##[0:4] fault_indicator_led_out)
    else $error("parameter error without fault LED");
  reset_func_a: assert property ($fell(sys_rst_in) |-> ch_func_out == {4{8'h09}})
    else $error("default function code wrong");
endmodule : analog_output_channel_control_asserts
bind analog_output_channel_control analog_output_channel_control_asserts chk (.clk_in,
  .sys_rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pstrb_in, .pready_out,
  .pslverr_out, .nv_write_out, .supply_missing_in, .prdata_out, .diag_record_out,
  .ch_code_out, .ch_func_out, .ch_active_out, .diag_send_out, .fault_indicator_led_out);

//--- sim/analog_output_channel_control_test.sv
// Self-checking bench: APB master tasks drive words and function codes.
// Assumes: update tick every 16 cycles; store model restores parameters.
`timescale 1ns/100ps
module analog_output_channel_control_test;
  import ao_ctrl_pkg::*;
  logic clk_in = 0, sys_rst_in = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, rec = 32'h0;
  logic [3:0]  pstrb = 4'h0, short_c = 4'h0, open_c = 4'h0;
  logic        supply = 0, malf = 0, pready, pslverr, nv_valid, nv_write, err, dsend, led;
  logic [47:0] nv_params, nv_data;
  logic [31:0] prdata, drec;
  code_vec_type codes;
  fn_vec_type   funcs;
  logic [3:0]   active;
  int bad_count = 0, cmp_count = 0;
  always #25 clk_in = ~clk_in;
  analog_output_channel_control #(.UPDATE_CYCLES(16)) uut (.clk_in, .sys_rst_in,
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .pstrb_in(pstrb), .pready_out(pready), .prdata_out(prdata),
    .pslverr_out(pslverr), .nv_valid_in(nv_valid), .nv_params_in(nv_params),
    .nv_write_out(nv_write), .nv_data_out(nv_data), .short_circuit_in(short_c),
    .open_circuit_in(open_c), .supply_missing_in(supply), .module_fault_in(malf),
    .ch_code_out(codes), .ch_active_out(active), .ch_func_out(funcs),
    .diag_send_out(dsend), .diag_record_out(drec), .fault_indicator_led_out(led));
  nv_store_model nv (.clk_in, .sys_rst_in, .nv_write_in(nv_write), .nv_data_in(nv_data),
    .nv_valid_out(nv_valid), .nv_params_out(nv_params));
  always @(posedge clk_in) if (dsend === 1'b1) rec <= drec;
  // ------------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_in);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk_in);
    penable <= 1;
    // Waits for the slave; only the watchdog ends a hang
    do begin @(posedge clk_in); end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  task round(input int v[4], input int e[4]);
    foreach (v[i]) apb(1, 8'(i * 8), {16'h0, 16'(v[i])}, 4'h3);
    repeat (40) @(posedge clk_in);
    foreach (e[i]) check({15'h0, codes[i]}, {15'h0, 17'(e[i])});
  endtask : round
  task give_verdict;
    $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict
  // ------------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------------
  initial begin
    #(5000 * 50);
    bad_count++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge clk_in);
    sys_rst_in <= 0;
    repeat (40) @(posedge clk_in);
    check(funcs, 32'h03050e0d);
    check({28'h0, active}, 32'hf);
    round('{27648, 32511, 16384, -20480}, '{27648, 32511, 27648, -34560});
    round('{-1, 32512, 20481, -20481}, '{0, 0, 0, 0});
    apb(1, 8'h48, 32'h09, 4'h1);
    apb(1, 8'h4c, 32'h0c, 4'h1);
    apb(1, 8'h50, 32'h04, 4'h1);
    apb(1, 8'h54, 32'hff, 4'h1);
    round('{-32512, -6912, -4096, 100}, '{-32512, -6912, -6912, 0});
    check({28'h0, active}, 32'h7);
    apb(1, 8'h48, 32'h00, 4'h1);
    apb(1, 8'h4c, 32'h07, 4'h1);
    repeat (40) @(posedge clk_in);
    check({funcs[1], funcs[0]}, 32'h0c09);
    check(rec, 32'h00000580);
    check({31'h0, led}, 32'h1);
    malf <= 1;
    repeat (20) @(posedge clk_in);
    check(rec, 32'h00000581);
    short_c <= 4'h1;
    repeat (20) @(posedge clk_in);
    check(rec, 32'h00001589);
    apb(0, 8'h40, 32'h0, 4'hf);
    check(rd, 32'h40);
    apb(0, 8'h4c, 32'h0, 4'hf);
    check(rd, 32'h07);
    apb(0, 8'hf0, 32'h0, 4'hf);
    check({31'h0, err}, 32'h1);
    supply <= 1;
    apb(0, 8'h88, 32'h0, 4'hf);
    check(rd, 32'h0);
    repeat (20) @(posedge clk_in);
    check(rec, 32'h0000158d);
    give_verdict();
  end
endmodule : analog_output_channel_control_test

//--- sim/nv_store_model.sv
// Behavioural non-volatile parameter store beside the control block.
// Assumes: same clock as the block; image survives the block's reset.
`timescale 1ns/100ps
module nv_store_model (
  input  wire logic        clk_in,        // Clock
  input  wire logic        sys_rst_in,    // Block reset
  input  wire logic        nv_write_in,   // Store pulse from block
  input  wire logic [47:0] nv_data_in,    // Image from block
  output logic             nv_valid_out,  // Saved image ready
  output logic [47:0]      nv_params_out  // Saved image
);
  logic [47:0] image_reg = 48'h03050e0d0040;
  logic [3:0]  wait_reg;
  logic        cap_reg;
  always_ff @(posedge clk_in) begin
    if (sys_rst_in) wait_reg <= 4'h0;
    else if (wait_reg != 4'hf) wait_reg <= wait_reg + 4'h1;
  end
  // Image offered once after reset, garbage otherwise
  assign nv_valid_out  = (wait_reg == 4'h3);
  assign nv_params_out = nv_valid_out ? image_reg : ~image_reg;
  always_ff @(posedge clk_in) begin
    cap_reg <= nv_write_in;
    if (cap_reg) image_reg <= nv_data_in;
  end
endmodule : nv_store_model
